// *** include/acs_pkg.sv ***
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ACS_OFF_CTRL   = 8'h00;
    localparam logic [7:0] ACS_OFF_STATUS = 8'h04;
    localparam logic [7:0] ACS_OFF_MASK   = 8'h08;
    localparam logic [7:0] ACS_OFF_RESULT = 8'h0C;
    localparam logic [7:0] ACS_OFF_LOW    = 8'h10;
    localparam logic [7:0] ACS_OFF_HIGH   = 8'h14;
    localparam logic [7:0] ACS_OFF_CMD    = 8'h18;
    // Control fields
    localparam int ACS_CTRL_CONV_EN   = 0;
    localparam int ACS_CTRL_BURST_EN  = 1;
    localparam int ACS_CTRL_WIN_OUT   = 2;
    localparam int ACS_CTRL_SRC_LSB   = 4;
    localparam int ACS_CTRL_RPT_LSB   = 8;
    localparam int ACS_CTRL_PWR_LSB   = 12;
    localparam logic [31:0] ACS_CTRL_MASK  = 32'h0000_F337;
    localparam logic [31:0] ACS_CTRL_RESET = 32'h0000_0000;
    // Start source select codes
    localparam logic [1:0] ACS_SRC_SW     = 2'h0;
    localparam logic [1:0] ACS_SRC_TIMER1 = 2'h1;
    localparam logic [1:0] ACS_SRC_TIMER2 = 2'h2;
    localparam logic [1:0] ACS_SRC_EXT    = 2'h3;
    // Status bits
    localparam int ACS_ST_DONE = 0;
    localparam int ACS_ST_WIN  = 1;
    localparam int ACS_ST_BUSY = 2;
    // Converter timing: 200 ksps needs 5 us per sample
    localparam int ACS_CLK_NS        = 100;
    localparam int ACS_SAMPLE_NS     = 5000;
    localparam int ACS_TRACK_NS      = 1500;
    localparam int ACS_PWR_STEP_NS   = 1600;
    localparam int ACS_SAMPLE_CYC    = ACS_SAMPLE_NS / ACS_CLK_NS;
    localparam int ACS_TRACK_CYC     = (ACS_TRACK_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    localparam int ACS_CONV_CYC      = ACS_SAMPLE_CYC - ACS_TRACK_CYC;
    localparam int ACS_PWR_STEP_CYC  = (ACS_PWR_STEP_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    localparam int ACS_MIN_START_CYC = 4;
    typedef enum logic [2:0] {
        ACS_IDLE  = 3'b000,
        ACS_PWRUP = 3'b001,
        ACS_TRACK = 3'b010,
        ACS_CONV  = 3'b011,
        ACS_WAIT  = 3'b100,
        ACS_DONE  = 3'b101
    } acs_state_t;
endpackage

// *** logic/acs_sequencer.sv ***
// What this block does
// - Conversion start from software, timer one, timer two or external pin.
// - Result completes after 1, 4, 8 or 16 accumulated samples.
// - Completed sum, 12 to 16 bits, latched into readable result register.
// - Completion sets done flag and raises interrupt when enabled.
// - Window compare flags result inside or outside limits, selectable.
// - Burst active exactly while burst enable bit is one.
// - Burst wakes, samples on the module clock, then returns to idle power.
// - Burst with converter enable zero powers down after each burst.
// - Burst with converter enable one stays powered between bursts.
// - Powered-down start waits programmed power-up time; powered start tracks at once.
// - Burst runs repeat count per start; otherwise one start per sample.
// - Done flag set only after full repeat count accumulated.
// - Window compare only on full sum, never partial sums.
// - Sequencing supports up to 200 ksps throughput only between samples within a burst.
// - Done and window flags each gated by own enable to interrupt.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer (
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        timer1_ovf_in,
    input  wire logic        timer2_ovf_in,
    input  wire logic        ext_start_in,
    input  wire logic [11:0] sample_data_in,
    output logic             converter_power_out,
    output logic             track_out,
    output logic             convert_out,
    output logic             irq_out
);
    typedef struct packed {
        logic [31:0]       ctrl;
        logic [1:0]        status;
        logic [1:0]        mask;
        logic [15:0]       result;
        logic [15:0]       low_lim;
        logic [15:0]       high_lim;
        logic [15:0]       acc;
        logic [4:0]        left;
        logic [9:0]        timer;
        logic [2:0]        gap;
        acs_pkg::acs_state_t st;
        logic              dp_wr;
        logic              dp_rd;
        logic [7:0]        dp_addr;
        logic [31:0]       rdata;
        logic [1:0]        ext_sync;
        logic              ext_prev;
        logic              pwr;
        logic              trk;
        logic              cnv;
        logic              irq;
    } acs_regs_t;

    acs_regs_t r;
    acs_regs_t next_r;

    logic        burst;
    logic [1:0]  src;
    logic [4:0]  rpt_n;
    logic [9:0]  pwr_cyc;
    logic        sw_start;
    logic        start;
    logic        addr_ok;
    logic [1:0]  w1c;
    logic [1:0]  ev;
    logic        in_win;
    logic [15:0] sum;
    logic [31:0] rd;

    always_comb begin
        burst   = r.ctrl[acs_pkg::ACS_CTRL_BURST_EN];
        src     = r.ctrl[acs_pkg::ACS_CTRL_SRC_LSB +: 2];
        case (r.ctrl[acs_pkg::ACS_CTRL_RPT_LSB +: 2])
            2'h0:    rpt_n = 5'h01;
            2'h1:    rpt_n = 5'h04;
            2'h2:    rpt_n = 5'h08;
            default: rpt_n = 5'h10;
        endcase
        pwr_cyc = 10'((r.ctrl[acs_pkg::ACS_CTRL_PWR_LSB +: 4] + 32'h1)
                      * acs_pkg::ACS_PWR_STEP_CYC);
        sw_start = r.dp_wr && (r.dp_addr == acs_pkg::ACS_OFF_CMD) && hwdata_in[0];
        case (src)
            acs_pkg::ACS_SRC_SW:     start = sw_start;
            acs_pkg::ACS_SRC_TIMER1: start = timer1_ovf_in;
            acs_pkg::ACS_SRC_TIMER2: start = timer2_ovf_in;
            default:                 start = r.ext_sync[1] && !r.ext_prev;
        endcase
        // Starts closer than four clocks are dropped in burst
        if (burst && r.gap != 3'h0) begin
            start = 1'b0;
        end
        sum    = r.acc + {4'h0, sample_data_in};
        // Compared on the held full sum only, never on a partial one
        in_win = (r.acc >= r.low_lim) && (r.acc <= r.high_lim);
        w1c    = 2'h0;
        if (r.dp_wr && r.dp_addr == acs_pkg::ACS_OFF_STATUS) begin
            w1c = hwdata_in[1:0];
        end
        ev = 2'h0;

        next_r          = r;
        next_r.ext_sync = {r.ext_sync[0], ext_start_in};
        next_r.ext_prev = r.ext_sync[1];
        next_r.gap      = (r.gap != 3'h0) ? r.gap - 3'h1 : 3'h0;
        if (start) begin
            next_r.gap = 3'(acs_pkg::ACS_MIN_START_CYC - 1);
        end
        if (r.timer != 10'h0) begin
            next_r.timer = r.timer - 10'h1;
        end

        case (r.st)
            acs_pkg::ACS_IDLE: begin
                next_r.pwr = r.ctrl[acs_pkg::ACS_CTRL_CONV_EN];
                if (start && (r.ctrl[acs_pkg::ACS_CTRL_CONV_EN] || burst)) begin
                    next_r.acc  = 16'h0000;
                    next_r.left = rpt_n;
                    next_r.pwr  = 1'b1;
                    if (!r.pwr) begin
                        next_r.st    = acs_pkg::ACS_PWRUP;
                        next_r.timer = pwr_cyc;
                    end else begin
                        next_r.st    = acs_pkg::ACS_TRACK;
                        next_r.trk   = 1'b1;
                        next_r.timer = 10'(acs_pkg::ACS_TRACK_CYC - 1);
                    end
                end
            end
            acs_pkg::ACS_PWRUP: begin
                if (r.timer == 10'h0) begin
                    next_r.st    = acs_pkg::ACS_TRACK;
                    next_r.trk   = 1'b1;
                    next_r.timer = 10'(acs_pkg::ACS_TRACK_CYC - 1);
                end
            end
            acs_pkg::ACS_TRACK: begin
                if (r.timer == 10'h0) begin
                    next_r.st    = acs_pkg::ACS_CONV;
                    next_r.trk   = 1'b0;
                    next_r.cnv   = 1'b1;
                    next_r.timer = 10'(acs_pkg::ACS_CONV_CYC - 1);
                end
            end
            acs_pkg::ACS_CONV: begin
                if (r.timer == 10'h0) begin
                    next_r.cnv  = 1'b0;
                    next_r.acc  = sum;
                    next_r.left = r.left - 5'h1;
                    if (r.left == 5'h01) begin
                        next_r.st = acs_pkg::ACS_DONE;
                    end else if (burst) begin
                        next_r.st    = acs_pkg::ACS_TRACK;
                        next_r.trk   = 1'b1;
                        next_r.timer = 10'(acs_pkg::ACS_TRACK_CYC - 1);
                    end else begin
                        next_r.st = acs_pkg::ACS_WAIT;
                    end
                end
            end
            acs_pkg::ACS_WAIT: begin
                if (start) begin
                    next_r.st    = acs_pkg::ACS_TRACK;
                    next_r.trk   = 1'b1;
                    next_r.timer = 10'(acs_pkg::ACS_TRACK_CYC - 1);
                end
            end
            acs_pkg::ACS_DONE: begin
                next_r.result = r.acc;
                ev[0] = 1'b1;
                if (in_win != r.ctrl[acs_pkg::ACS_CTRL_WIN_OUT]) begin
                    ev[1] = 1'b1;
                end
                // Idle power state follows converter enable
                next_r.pwr = r.ctrl[acs_pkg::ACS_CTRL_CONV_EN];
                next_r.st  = acs_pkg::ACS_IDLE;
            end
            default: begin
                next_r.st = acs_pkg::ACS_IDLE;
            end
        endcase

        // Set beats clear
        next_r.status = (r.status & ~w1c) | ev;

        next_r.dp_wr = 1'b0;
        next_r.dp_rd = 1'b0;
        if (r.dp_wr) begin
            case (r.dp_addr)
                acs_pkg::ACS_OFF_CTRL: next_r.ctrl = hwdata_in & acs_pkg::ACS_CTRL_MASK;
                acs_pkg::ACS_OFF_MASK: next_r.mask = hwdata_in[1:0];
                acs_pkg::ACS_OFF_LOW:  next_r.low_lim = hwdata_in[15:0];
                acs_pkg::ACS_OFF_HIGH: next_r.high_lim = hwdata_in[15:0];
                default: ;
            endcase
        end
        addr_ok = haddr_in[31:8] == 24'h0;
        if (hsel_in && hready_in && htrans_in[1] && addr_ok) begin
            next_r.dp_wr   = hwrite_in;
            next_r.dp_rd   = !hwrite_in;
            next_r.dp_addr = {haddr_in[7:2], 2'b00};
        end
        case (haddr_in[7:0] & 8'hFC)
            acs_pkg::ACS_OFF_CTRL:   rd = r.ctrl;
            acs_pkg::ACS_OFF_STATUS: rd = {29'h0, r.st != acs_pkg::ACS_IDLE, r.status};
            acs_pkg::ACS_OFF_MASK:   rd = {30'h0, r.mask};
            acs_pkg::ACS_OFF_RESULT: rd = {16'h0, r.result};
            acs_pkg::ACS_OFF_LOW:    rd = {16'h0, r.low_lim};
            acs_pkg::ACS_OFF_HIGH:   rd = {16'h0, r.high_lim};
            default:                 rd = 32'h0000_0000;
        endcase
        if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            next_r.rdata = addr_ok ? rd : 32'h0000_0000;
        end
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata_out          = r.rdata;
    assign hreadyout_out       = 1'b1;
    assign hresp_out           = 1'b0;
    assign converter_power_out = r.pwr;
    assign track_out           = r.trk;
    assign convert_out         = r.cnv;
    assign irq_out             = r.irq;
endmodule
`default_nettype wire

// *** test/acs_sequencer_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_monitor (
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    input wire logic        hsel_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        converter_power_out,
    input wire logic        track_out,
    input wire logic        convert_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_track_hold;
        track_out [*8];
    endsequence
    sequence s_conv_hold;
        convert_out [*8];
    endsequence
    AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("bus answered with wait or error");
    AST_TRACK_HOLD: assert property ($rose(track_out) |-> s_track_hold)
        else $error("tracking cut short");
    AST_CONV_FOLLOWS: assert property ($fell(track_out) |-> s_conv_hold)
        else $error("conversion did not follow tracking");
    AST_CONV_CAUSE: assert property ($rose(convert_out) |-> $past(track_out))
        else $error("conversion without tracking");
    AST_EXCLUSIVE: assert property (!(track_out && convert_out))
        else $error("tracking and converting together");
    AST_POWERED: assert property ((track_out || convert_out) |-> converter_power_out)
        else $error("active while powered down");
    AST_PWR_WAIT: assert property ($rose(converter_power_out) |-> !track_out [*8])
        else $error("tracking before power-up wait");
    AST_IRQ_AFTER: assert property ($rose(irq_out) |-> !track_out && !convert_out)
        else $error("interrupt during a sequence");
    AST_RDATA_HOLD: assert property (
        !$past(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |-> $stable(hrdata_out))
        else $error("read data changed without a read");
endmodule
bind acs_sequencer acs_sequencer_monitor u_acs_sequencer_monitor (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .converter_power_out(converter_power_out),
    .track_out(track_out), .convert_out(convert_out), .irq_out(irq_out));
`default_nettype wire

// *** test/acs_start_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module acs_start_model #(
    parameter logic [11:0] SAMPLE = 12'hABC
) (
    input wire logic        mclk_in,
    input wire logic [2:0]  kick_in,
    input wire logic        convert_in,
    output logic            timer1_ovf_out,
    output logic            timer2_ovf_out,
    output logic            ext_start_out,
    output logic     [11:0] sample_data_out
);
    logic [3:0] ext_cnt;
    initial begin
        timer1_ovf_out = 1'b0;
        timer2_ovf_out = 1'b0;
        ext_cnt = 4'h0;
    end
    always @(posedge mclk_in) begin
        timer1_ovf_out <= kick_in[0];
        timer2_ovf_out <= kick_in[1];
        // Long level so the synchroniser sees it; bench spaces starts widely
        if (kick_in[2])
            ext_cnt <= 4'hF;
        else if (ext_cnt != 4'h0)
            ext_cnt <= ext_cnt - 4'h1;
    end
    assign ext_start_out = (ext_cnt != 4'h0);
    // Garbage outside conversion so a stray sample shows
    assign sample_data_out = convert_in ? SAMPLE : ~SAMPLE;
endmodule
`default_nettype wire

// *** test/test_adc_conversion_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
`define ACS_EXPECT(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end
module test_adc_conversion_sequencer;
    localparam logic [11:0] SAMPLE = 12'hABC;
    logic        mclk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  kick = 3'h0;
    logic [31:0] hrdata, rd;
    logic        hready, hresp, t1, t2, ext, pwr, trk, cnv, irq;
    logic [11:0] sample;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          waited = 0;
    always #50 mclk_in = ~mclk_in;
    acs_sequencer u_acs_sequencer (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .timer1_ovf_in(t1), .timer2_ovf_in(t2), .ext_start_in(ext),
        .sample_data_in(sample), .converter_power_out(pwr), .track_out(trk),
        .convert_out(cnv), .irq_out(irq));
    acs_start_model #(.SAMPLE(SAMPLE)) u_acs_start_model (.mclk_in(mclk_in), .kick_in(kick),
        .convert_in(cnv), .timer1_ovf_out(t1), .timer2_ovf_out(t2), .ext_start_out(ext),
        .sample_data_out(sample));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pulse(input int i);
        @(posedge mclk_in);
        kick[i] <= 1'b1;
        @(posedge mclk_in);
        kick <= 3'h0;
    endtask
    task automatic wait_irq();
        waited = 0;
        while (waited < 2000 && irq !== 1'b1) begin
            @(posedge mclk_in);
            waited++;
        end
        `ACS_EXPECT(irq, 1'b1);
    endtask
    task automatic sw_single();
        ahb(1, acs_pkg::ACS_OFF_CTRL, 32'h1);
        ahb(1, acs_pkg::ACS_OFF_CMD, 32'h1);
        wait_irq();
        `ACS_EXPECT(waited <= acs_pkg::ACS_SAMPLE_CYC + 2, 1'b1);
        ahb(0, acs_pkg::ACS_OFF_RESULT, 32'h0);
        `ACS_EXPECT(rd, {20'h0, SAMPLE});
        ahb(0, acs_pkg::ACS_OFF_STATUS, 32'h0);
        `ACS_EXPECT(rd, 32'h3);
        ahb(1, acs_pkg::ACS_OFF_STATUS, 32'h3);
        ahb(0, acs_pkg::ACS_OFF_STATUS, 32'h0);
        `ACS_EXPECT(rd, 32'h0);
        `ACS_EXPECT(irq, 1'b0);
    endtask
    task automatic burst_timer1();
        // Partial sums lie outside a one-point window; only the full sum is inside
        ahb(1, acs_pkg::ACS_OFF_LOW, {18'h0, SAMPLE, 2'h0});
        ahb(1, acs_pkg::ACS_OFF_HIGH, {18'h0, SAMPLE, 2'h0});
        ahb(1, acs_pkg::ACS_OFF_CTRL, 32'h116);
        // Idle power follows the new enable one clock after the write lands
        repeat (2) @(posedge mclk_in);
        `ACS_EXPECT(pwr, 1'b0);
        pulse(0);
        wait_irq();
        `ACS_EXPECT(waited >= 4 * acs_pkg::ACS_SAMPLE_CYC + acs_pkg::ACS_PWR_STEP_CYC, 1'b1);
        ahb(0, acs_pkg::ACS_OFF_RESULT, 32'h0);
        `ACS_EXPECT(rd, {18'h0, SAMPLE, 2'h0});
        ahb(0, acs_pkg::ACS_OFF_STATUS, 32'h0);
        `ACS_EXPECT(rd, 32'h1);
        `ACS_EXPECT(pwr, 1'b0);
        ahb(1, acs_pkg::ACS_OFF_STATUS, 32'h3);
    endtask
    task automatic burst_ext();
        ahb(1, acs_pkg::ACS_OFF_LOW, 32'h0);
        ahb(1, acs_pkg::ACS_OFF_HIGH, 32'hFFFF);
        ahb(1, acs_pkg::ACS_OFF_CTRL, 32'h333);
        pulse(2);
        wait_irq();
        `ACS_EXPECT(waited < 16 * acs_pkg::ACS_SAMPLE_CYC + acs_pkg::ACS_PWR_STEP_CYC, 1'b1);
        ahb(0, acs_pkg::ACS_OFF_RESULT, 32'h0);
        `ACS_EXPECT(rd, {16'h0, SAMPLE, 4'h0});
        ahb(0, acs_pkg::ACS_OFF_STATUS, 32'h0);
        `ACS_EXPECT(rd, 32'h3);
        `ACS_EXPECT(pwr, 1'b1);
        ahb(1, acs_pkg::ACS_OFF_STATUS, 32'h3);
    endtask
    task automatic timer2_steps();
        ahb(1, acs_pkg::ACS_OFF_MASK, 32'h0);
        ahb(1, acs_pkg::ACS_OFF_CTRL, 32'h221);
        for (int i = 0; i < 8; i++) begin
            pulse(1);
            repeat (60) @(posedge mclk_in);
            ahb(0, acs_pkg::ACS_OFF_STATUS, 32'h0);
            `ACS_EXPECT(rd[0], (i == 7));
        end
        `ACS_EXPECT(irq, 1'b0);
        ahb(0, acs_pkg::ACS_OFF_RESULT, 32'h0);
        `ACS_EXPECT(rd, {17'h0, SAMPLE, 3'h0});
        ahb(1, acs_pkg::ACS_OFF_MASK, 32'h2);
        repeat (2) @(posedge mclk_in);
        `ACS_EXPECT(irq, 1'b1);
        ahb(1, acs_pkg::ACS_OFF_STATUS, 32'h2);
        repeat (2) @(posedge mclk_in);
        `ACS_EXPECT(irq, 1'b0);
        ahb(0, acs_pkg::ACS_OFF_CTRL, 32'h0);
        `ACS_EXPECT(rd, 32'h221);
    endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        ahb(1, acs_pkg::ACS_OFF_MASK, 32'h3);
        ahb(1, acs_pkg::ACS_OFF_HIGH, 32'hFFFF);
        sw_single();
        burst_timer1();
        burst_ext();
        timer2_steps();
        ahb(0, 8'h40, 32'h0);
        `ACS_EXPECT(rd, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
